// file: rtl/twi_regs_defs.svh
// register offsets, field positions and reset values of the serial bus register slice
`ifndef TWI_REGS_DEFS_SVH
`define TWI_REGS_DEFS_SVH

`define ADDR_MASK_BASE 12'h000
`define BAUD_DIV_BASE 12'h010
`define TX_BYTE_BASE 12'h020
`define RX_BYTE_BASE 12'h030
`define IRQ_FLAGS_BASE 12'h040
`define IRQ_ENABLES_BASE 12'h050
`define IRQ_PRIORITY_BASE 12'h060
`define BUS_STATUS_BASE 12'h070

`define ALIAS_PLAIN 2'h0
`define ALIAS_CLEAR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_TOGGLE 2'h3

`define ADDR_MASK_IMPL 32'h0000_03ff
`define BAUD_DIV_IMPL 32'h0000_0fff
`define TX_BYTE_IMPL 32'h0000_00ff
`define IRQ_FLAGS_IMPL 32'he000_0000
`define IRQ_ENABLES_IMPL 32'he000_0000
`define IRQ_PRIORITY_IMPL 32'h0000_1f00
`define BUS_STATUS_IMPL 32'h0000_0004

`define MASTER_BIT 31
`define SLAVE_BIT 30
`define COLLISION_BIT 29
`define LEVEL_LSB 10
`define SUBLEVEL_LSB 8
`define RX_FULL_BIT 0
`define TX_FULL_BIT 1
`define WCOL_BIT 2

`define REG_RESET 32'h0000_0000
`define UNMAPPED_READ 32'h0000_0000

`endif

// file: rtl/twi_regs_pkg.sv
// types shared by the serial bus register slice
package twi_regs_pkg;

    typedef struct packed {
        logic master;
        logic slave;
        logic collision;
    } irq_events_t;

    typedef struct packed {
        logic [2:0] level;
        logic [1:0] sublevel;
    } irq_route_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } bus_req_t;

endpackage

// file: rtl/alias_apply.sv
// applies a plain, clear, set or toggle write to one register under its implemented-bit mask
`timescale 1ns/1ps
`include "twi_regs_defs.svh"

module alias_apply #(
    parameter logic [31:0] IMPL = 32'hffff_ffff
) (
    input wire logic [31:0] cur_i,
    input wire logic [31:0] data_i,
    input wire logic [1:0] kind_i,
    output logic [31:0] val_o
);
    logic [31:0] raw;

    // only implemented bits ever move; reserved bits keep their value from cur_i
    always_comb begin
        raw = cur_i;
        case (kind_i)
            `ALIAS_CLEAR: raw = cur_i & ~data_i;
            `ALIAS_SET: raw = cur_i | data_i;
            `ALIAS_TOGGLE: raw = cur_i ^ data_i;
            default: raw = data_i;
        endcase
        val_o = (raw & IMPL) | (cur_i & ~IMPL);
    end
endmodule

// file: rtl/event_flag.sv
// sticky flag set by a one-cycle pulse, written by software, set wins over clear
`timescale 1ns/1ps

module event_flag (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic pulse_i,
    input wire logic wr_i,
    input wire logic wval_i,
    output logic flag_o
);
    logic flag_r;
    logic flag_nxt;

    always_comb begin
        flag_nxt = flag_r;
        if (wr_i) begin
            flag_nxt = wval_i;
        end
        if (pulse_i) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_o = flag_r;
endmodule

// file: rtl/twi_regs.sv
// register slice of the two-wire serial controller on an ahb-lite slave port
//
// Behaviour
// - clear alias zeroes bits written one
// - set alias forces bits written one
// - toggle alias inverts bits, mask included
// - zero bits, reserved bits stay unchanged
// - alias reads return no meaningful value
// - twelve-bit divider, resets zero
// - reserved upper bits write-ignored, read zero
// - eight-bit transmit byte, resets zero
// - receive byte read-only, writes ignored
// - bit 31 master event flag
// - bit 30 slave event flag
// - bit 29 collision event flag
// - flag one means request pending
// - bits 31,30 enable master, slave
// - bit 29 enables collision interrupt
// - level bits 12:10, zero disables
// - level codes one to seven
// - sublevel bits 9:8 direct value
// - rx full set on receive, cleared read
// - tx full while byte held, busy
// - tx write while busy sets collision
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "twi_regs_defs.svh"

module twi_regs (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire twi_regs_pkg::irq_events_t event_pulse_i,
    input wire logic rx_done_i,
    input wire logic [7:0] rx_data_i,
    input wire logic tx_done_i,
    input wire logic engine_busy_i,
    output logic [11:0] baud_divider_value_o,
    output logic [9:0] address_mask_reg_o,
    output logic [7:0] tx_byte_field_o,
    output logic tx_start_o,
    output logic irq_req_o,
    output twi_regs_pkg::irq_route_t irq_route_o
);
    typedef struct packed {
        twi_regs_pkg::bus_req_t req;
        logic [31:0] rdata;
        logic [9:0] mask;
        logic [11:0] baud;
        logic [7:0] tx_byte;
        logic [7:0] rx_byte;
        logic rx_full;
        logic tx_full;
        logic wcol;
        logic tx_start;
        logic [2:0] enables;
        logic [2:0] level;
        logic [1:0] sublevel;
        logic irq_req;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [2:0] flags;
    logic [31:0] flags_word;
    logic [31:0] en_word;
    logic [31:0] prio_word;
    logic [31:0] status_word;
    logic [31:0] mask_new;
    logic [31:0] baud_new;
    logic [31:0] tx_new;
    logic [31:0] en_new;
    logic [31:0] prio_new;
    logic [31:0] status_new;
    logic [31:0] flags_new;
    logic wr_phase;
    logic [1:0] wr_kind;
    logic [11:0] wr_base;
    logic flags_wr;
    logic [2:0] pulses;
    logic [2:0] flags_next;

    // address phase taken when selected, ready and htrans is NONSEQ or SEQ (BUSY is not taken)
    assign wr_phase = st_r.req.valid && st_r.req.write;
    assign wr_kind = st_r.req.addr[3:2];
    assign wr_base = {st_r.req.addr[11:4], 4'h0};

    // read views of the implemented fields
    assign flags_word = {flags, 29'h0000_0000};
    assign en_word = {st_r.enables, 29'h0000_0000};
    assign prio_word = {19'h0_0000, st_r.level, st_r.sublevel, 8'h00};
    assign status_word = {29'h0000_0000, st_r.wcol, st_r.tx_full, st_r.rx_full};

    alias_apply #(.IMPL(`ADDR_MASK_IMPL)) u_mask (
        .cur_i({22'h00_0000, st_r.mask}),
        .data_i(hwdata_i),
        .kind_i(wr_kind),
        .val_o(mask_new)
    );

    alias_apply #(.IMPL(`BAUD_DIV_IMPL)) u_baud (
        .cur_i({20'h0_0000, st_r.baud}),
        .data_i(hwdata_i),
        .kind_i(wr_kind),
        .val_o(baud_new)
    );

    alias_apply #(.IMPL(`TX_BYTE_IMPL)) u_tx (
        .cur_i({24'h00_0000, st_r.tx_byte}),
        .data_i(hwdata_i),
        .kind_i(wr_kind),
        .val_o(tx_new)
    );

    alias_apply #(.IMPL(`IRQ_ENABLES_IMPL)) u_en (
        .cur_i(en_word),
        .data_i(hwdata_i),
        .kind_i(wr_kind),
        .val_o(en_new)
    );

    alias_apply #(.IMPL(`IRQ_PRIORITY_IMPL)) u_prio (
        .cur_i(prio_word),
        .data_i(hwdata_i),
        .kind_i(wr_kind),
        .val_o(prio_new)
    );

    alias_apply #(.IMPL(`BUS_STATUS_IMPL)) u_stat (
        .cur_i(status_word),
        .data_i(hwdata_i),
        .kind_i(wr_kind),
        .val_o(status_new)
    );

    alias_apply #(.IMPL(`IRQ_FLAGS_IMPL)) u_flg (
        .cur_i(flags_word),
        .data_i(hwdata_i),
        .kind_i(wr_kind),
        .val_o(flags_new)
    );

    assign flags_wr = wr_phase && (wr_base == `IRQ_FLAGS_BASE);
    assign pulses = {event_pulse_i.master, event_pulse_i.slave, event_pulse_i.collision};
    // flag values after this edge, so a read sees a write or event landing now
    assign flags_next = pulses | (flags_wr ? flags_new[31:29] : flags);

    // one sticky flag per event source
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            event_flag u_flag (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .pulse_i(pulses[gi]),
                .wr_i(flags_wr),
                .wval_i(flags_new[`COLLISION_BIT + gi]),
                .flag_o(flags[gi])
            );
        end
    endgenerate

    // main next-state: bus slave, register writes, status tracking
    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_start = 1'b0;
        st_nxt.req.valid = 1'b0;
        if (hsel_i && hready_i && htrans_i[1]) begin
            st_nxt.req.valid = 1'b1;
            st_nxt.req.write = hwrite_i;
            st_nxt.req.addr = haddr_i[11:0];
        end
        if (tx_done_i) begin
            st_nxt.tx_full = 1'b0;
        end
        if (rx_done_i) begin
            st_nxt.rx_byte = rx_data_i;
            st_nxt.rx_full = 1'b1;
        end
        if (wr_phase) begin
            if (wr_base == `ADDR_MASK_BASE) begin
                st_nxt.mask = mask_new[9:0];
            end else if (wr_base == `BAUD_DIV_BASE) begin
                st_nxt.baud = baud_new[11:0];
            end else if (wr_base == `TX_BYTE_BASE) begin
                if (engine_busy_i || st_r.tx_full) begin
                    st_nxt.wcol = 1'b1;
                end else begin
                    st_nxt.tx_byte = tx_new[7:0];
                    st_nxt.tx_full = 1'b1;
                    st_nxt.tx_start = 1'b1;
                end
            end else if (wr_base == `IRQ_ENABLES_BASE) begin
                st_nxt.enables = en_new[31:29];
            end else if (wr_base == `IRQ_PRIORITY_BASE) begin
                st_nxt.level = prio_new[12:10];
                st_nxt.sublevel = prio_new[9:8];
            end else if (wr_base == `BUS_STATUS_BASE) begin
                // software write, any alias sets or clears it; no collision can land in the same cycle, it needs a transmit-byte write
                st_nxt.wcol = status_new[`WCOL_BIT];
            end
        end
        // reading the receive byte empties it unless a new byte lands
        if (st_r.req.valid && !st_r.req.write && st_r.req.addr == `RX_BYTE_BASE && !rx_done_i) begin
            st_nxt.rx_full = 1'b0;
        end
        // read data registered at the address phase for a zero-wait answer;
        // built from the next state, so a write finishing its data phase now
        // is already seen by a back-to-back read
        st_nxt.rdata = `UNMAPPED_READ;
        if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
            if (haddr_i[3:2] != `ALIAS_PLAIN) begin
                st_nxt.rdata = `UNMAPPED_READ;
            end else if (haddr_i[11:4] == `ADDR_MASK_BASE >> 4) begin
                st_nxt.rdata = {22'h00_0000, st_nxt.mask};
            end else if (haddr_i[11:4] == `BAUD_DIV_BASE >> 4) begin
                st_nxt.rdata = {20'h0_0000, st_nxt.baud};
            end else if (haddr_i[11:4] == `TX_BYTE_BASE >> 4) begin
                st_nxt.rdata = {24'h00_0000, st_nxt.tx_byte};
            end else if (haddr_i[11:4] == `RX_BYTE_BASE >> 4) begin
                st_nxt.rdata = {24'h00_0000, st_nxt.rx_byte};
            end else if (haddr_i[11:4] == `IRQ_FLAGS_BASE >> 4) begin
                st_nxt.rdata = {flags_next, 29'h0000_0000};
            end else if (haddr_i[11:4] == `IRQ_ENABLES_BASE >> 4) begin
                st_nxt.rdata = {st_nxt.enables, 29'h0000_0000};
            end else if (haddr_i[11:4] == `IRQ_PRIORITY_BASE >> 4) begin
                st_nxt.rdata = {19'h0_0000, st_nxt.level, st_nxt.sublevel, 8'h00};
            end else if (haddr_i[11:4] == `BUS_STATUS_BASE >> 4) begin
                st_nxt.rdata = {29'h0000_0000, st_nxt.wcol, st_nxt.tx_full, st_nxt.rx_full};
            end
        end
        // flag and enable and nonzero level
        // any level one to seven raises
        st_nxt.irq_req = (|(flags & st_r.enables)) && (st_r.level != 3'h0);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs from the state register, except hreadyout_o and hresp_o tied constant
    assign hrdata_o = st_r.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign baud_divider_value_o = st_r.baud;
    assign address_mask_reg_o = st_r.mask;
    assign tx_byte_field_o = st_r.tx_byte;
    assign tx_start_o = st_r.tx_start;
    assign irq_req_o = st_r.irq_req;
    assign irq_route_o = '{level: st_r.level, sublevel: st_r.sublevel};

    AST_LEVEL_ZERO_SILENT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $past(st_r.level) == 3'h0 |-> !irq_req_o) else $error("irq raised at level zero");
    // event pulse reaches flag next cycle
    AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        event_pulse_i.master |=> flags[2]) else $error("master flag not set");
    AST_WCOL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_phase && wr_base == `TX_BYTE_BASE && engine_busy_i |=> st_r.wcol && $stable(st_r.tx_byte))
        else $error("collision not flagged");
    // rx byte changes only on receive
    AST_RX_RO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !rx_done_i |=> $stable(st_r.rx_byte)) else $error("rx byte changed without receive");
    AST_RX_FULL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rx_done_i |=> st_r.rx_full) else $error("rx full not set");
    AST_BAUD_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_phase && wr_base == `BAUD_DIV_BASE && wr_kind == `ALIAS_CLEAR
        |=> st_r.baud == ($past(st_r.baud) & ~$past(hwdata_i[11:0]))) else $error("clear alias wrong");
    AST_BAUD_SET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_phase && wr_base == `BAUD_DIV_BASE && wr_kind == `ALIAS_SET
        |=> st_r.baud == ($past(st_r.baud) | $past(hwdata_i[11:0]))) else $error("set alias wrong");
    AST_MASK_INV: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_phase && wr_base == `ADDR_MASK_BASE && wr_kind == `ALIAS_TOGGLE
        |=> st_r.mask == ($past(st_r.mask) ^ $past(hwdata_i[9:0]))) else $error("toggle alias wrong");
    AST_TX_DONE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tx_done_i && !wr_phase |=> !st_r.tx_full) else $error("tx full not cleared");
    AST_SLAVE_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        event_pulse_i.slave |=> flags[1]) else $error("slave flag not set");
    AST_COLL_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        event_pulse_i.collision |=> flags[0]) else $error("collision flag not set");
    // request only behind an enabled flag
    AST_IRQ_NEEDS_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_req_o |-> $past(|(flags & st_r.enables))) else $error("irq raised with no enabled flag");
    AST_IRQ_GATED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (flags & st_r.enables) == 3'h0 |=> !irq_req_o) else $error("irq raised while disabled");
    AST_ALIAS_READ: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[3:2] != `ALIAS_PLAIN
        |=> hrdata_o == `UNMAPPED_READ) else $error("alias read not zero");
    AST_RD_BAUD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[11:0] == `BAUD_DIV_BASE
        |=> hrdata_o == {20'h0_0000, baud_divider_value_o}) else $error("divider read stale");
    AST_TX_LOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_phase && wr_base == `TX_BYTE_BASE && !engine_busy_i && !st_r.tx_full
        |=> st_r.tx_full && tx_start_o) else $error("accepted byte not marked full");
    AST_START_ONE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tx_start_o |=> !tx_start_o) else $error("transmit start held too long");
    // collision flag moves only on writes
    AST_WCOL_STICKY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !wr_phase |=> $stable(st_r.wcol)) else $error("collision flag changed without write");
endmodule

// file: bench/twi_regs_test.sv
// self-checking bench for the serial bus register slice, driven over ahb-lite
`timescale 1ns/1ps
`include "twi_regs_defs.svh"

module twi_regs_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    twi_regs_pkg::irq_events_t event_pulse_i = '0;
    logic rx_done_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    logic tx_done_i = 1'b0;
    logic engine_busy_i = 1'b0;
    logic [11:0] baud_divider_value_o;
    logic [9:0] address_mask_reg_o;
    logic [7:0] tx_byte_field_o;
    logic tx_start_o;
    logic irq_req_o;
    twi_regs_pkg::irq_route_t irq_route_o;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rd_q;
    logic [2:0] lvl;

    // the single slave's hreadyout is the bus hready
    twi_regs u_dut (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .event_pulse_i(event_pulse_i),
        .rx_done_i(rx_done_i),
        .rx_data_i(rx_data_i),
        .tx_done_i(tx_done_i),
        .engine_busy_i(engine_busy_i),
        .baud_divider_value_o(baud_divider_value_o),
        .address_mask_reg_o(address_mask_reg_o),
        .tx_byte_field_o(tx_byte_field_o),
        .tx_start_o(tx_start_o),
        .irq_req_o(irq_req_o),
        .irq_route_o(irq_route_o)
    );

    // 250 mhz clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // address phase held until hready, then data phase until hready again
    task automatic bus(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {20'h0_0000, a};
        htrans_i <= 2'h2;
        hwrite_i <= is_wr;
        hsize_i <= 3'h2;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= is_wr ? d : 32'h0000_0000;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd_q = hrdata_o;
        check("response", {31'h0, hresp_o}, 32'h0000_0000);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(what, rd_q, exp);
    endtask

    // one-cycle strobes from the bus engine side
    task automatic strobe(input twi_regs_pkg::irq_events_t e, input logic rx, input logic tx);
        @(posedge clk_i);
        event_pulse_i <= e;
        rx_done_i <= rx;
        tx_done_i <= tx;
        @(posedge clk_i);
        event_pulse_i <= '0;
        rx_done_i <= 1'b0;
        tx_done_i <= 1'b0;
        #1;
    endtask

    // request is registered, so let two edges pass before looking
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk_i);
        #1;
        check("irq request", {31'h0, irq_req_o}, {31'h0, exp});
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset value", 12'(i * 16), `REG_RESET);
        end
        rd_chk("unmapped", 12'h0fc, `UNMAPPED_READ);
        $display("test reset done");

        wr(`BAUD_DIV_BASE, 32'hffff_ffff);
        rd_chk("baud full", `BAUD_DIV_BASE, 32'h0000_0fff);
        check("baud out", {20'h0, baud_divider_value_o}, 32'h0000_0fff);
        wr(`BAUD_DIV_BASE + 12'h004, 32'h0000_8001);
        rd_chk("baud clear", `BAUD_DIV_BASE, 32'h0000_0ffe);
        wr(`BAUD_DIV_BASE + 12'h008, 32'h0000_8001);
        rd_chk("baud set", `BAUD_DIV_BASE, 32'h0000_0fff);
        wr(`BAUD_DIV_BASE + 12'h00c, 32'h0000_8001);
        rd_chk("baud toggle", `BAUD_DIV_BASE, 32'h0000_0ffe);
        rd_chk("alias read", `BAUD_DIV_BASE + 12'h00c, `UNMAPPED_READ);
        wr(`ADDR_MASK_BASE + 12'h00c, 32'h0000_8001);
        rd_chk("mask toggle", `ADDR_MASK_BASE, 32'h0000_0001);
        wr(`ADDR_MASK_BASE + 12'h00c, 32'hffff_ffff);
        check("mask out", {22'h0, address_mask_reg_o}, 32'h0000_03fe);
        $display("test aliases done");

        wr(`TX_BYTE_BASE, 32'hffff_ff5a);
        check("tx start", {31'h0, tx_start_o}, 32'h0000_0001);
        rd_chk("tx byte", `TX_BYTE_BASE, 32'h0000_005a);
        check("tx out", {24'h0, tx_byte_field_o}, 32'h0000_005a);
        rd_chk("status tx full", `BUS_STATUS_BASE, 32'h0000_0002);
        strobe('0, 1'b0, 1'b1);
        rd_chk("status tx done", `BUS_STATUS_BASE, 32'h0000_0000);
        // write while the engine is busy is refused and flagged
        @(posedge clk_i);
        engine_busy_i <= 1'b1;
        wr(`TX_BYTE_BASE, 32'h0000_0033);
        check("tx no start", {31'h0, tx_start_o}, 32'h0000_0000);
        rd_chk("tx kept", `TX_BYTE_BASE, 32'h0000_005a);
        rd_chk("status wcol", `BUS_STATUS_BASE, 32'h0000_0004);
        @(posedge clk_i);
        engine_busy_i <= 1'b0;
        wr(`BUS_STATUS_BASE + 12'h004, 32'h0000_0004);
        rd_chk("wcol cleared", `BUS_STATUS_BASE, 32'h0000_0000);
        // toggle alias on the transmit byte loads the held byte xor the written data
        wr(`TX_BYTE_BASE + 12'h00c, 32'h0000_00ff);
        check("tx toggle start", {31'h0, tx_start_o}, 32'h0000_0001);
        rd_chk("tx toggle", `TX_BYTE_BASE, 32'h0000_00a5);
        strobe('0, 1'b0, 1'b1);
        $display("test transmit done");

        @(posedge clk_i);
        rx_data_i <= 8'hc3;
        strobe('0, 1'b1, 1'b0);
        rd_chk("status rx full", `BUS_STATUS_BASE, 32'h0000_0001);
        rd_chk("rx byte", `RX_BYTE_BASE, 32'h0000_00c3);
        rd_chk("status rx empty", `BUS_STATUS_BASE, 32'h0000_0000);
        wr(`RX_BYTE_BASE, 32'h0000_00ff);
        rd_chk("rx read only", `RX_BYTE_BASE, 32'h0000_00c3);
        $display("test receive done");

        strobe(3'b100, 1'b0, 1'b0);
        rd_chk("master flag", `IRQ_FLAGS_BASE, 32'h8000_0000);
        irq_chk(1'b0);
        strobe(3'b010, 1'b0, 1'b0);
        rd_chk("slave flag", `IRQ_FLAGS_BASE, 32'hc000_0000);
        strobe(3'b001, 1'b0, 1'b0);
        rd_chk("collision flag", `IRQ_FLAGS_BASE, 32'he000_0000);
        wr(`IRQ_FLAGS_BASE + 12'h004, 32'h6000_0000);
        rd_chk("flags cleared", `IRQ_FLAGS_BASE, 32'h8000_0000);
        wr(`IRQ_ENABLES_BASE, 32'hffff_ffff);
        rd_chk("enables", `IRQ_ENABLES_BASE, 32'he000_0000);
        // every level code with a matching sublevel
        for (int i = 0; i < 8; i++) begin
            lvl = 3'(i);
            wr(`IRQ_PRIORITY_BASE, {19'h0, lvl, lvl[1:0], 8'h00});
            rd_chk("priority", `IRQ_PRIORITY_BASE, {19'h0, lvl, lvl[1:0], 8'h00});
            check("route", {27'h0, irq_route_o}, {27'h0, lvl, lvl[1:0]});
            irq_chk(lvl != 3'h0);
        end
        wr(`IRQ_ENABLES_BASE + 12'h004, 32'hc000_0000);
        irq_chk(1'b0);
        strobe(3'b001, 1'b0, 1'b0);
        irq_chk(1'b1);
        wr(`IRQ_ENABLES_BASE + 12'h004, 32'h2000_0000);
        irq_chk(1'b0);
        wr(`IRQ_PRIORITY_BASE, 32'hffff_ffff);
        rd_chk("priority reserved", `IRQ_PRIORITY_BASE, 32'h0000_1f00);
        $display("test interrupts done");

        // a second reset mid-run must bring every register back to zero
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk("re-reset value", 12'(i * 16), `REG_RESET);
        end
        check("irq after reset", {31'h0, irq_req_o}, 32'h0000_0000);
        $display("test second reset done");
        results();
    end
endmodule
